// ==== shared/als_pkg.sv ====
// Constants, types and opcodes shared by the ambient light command and readout design.
package als_pkg;
  localparam logic [7:0] OP_POWER_DOWN = 8'h00;
  localparam logic [7:0] OP_POWER_ON = 8'h01;
  localparam logic [7:0] OP_CLEAR = 8'h07;
  localparam logic [7:0] OP_CONT_FINE = 8'h10;
  localparam logic [7:0] OP_CONT_COARSE = 8'h13;
  localparam logic [7:0] OP_ONCE_FINE = 8'h20;
  localparam logic [7:0] OP_ONCE_COARSE = 8'h23;
  localparam int FIELD_HI_W = 3;
  localparam int FIELD_LO_W = 5;
  localparam logic [4:0] OP_FIELD_HI_PREFIX = 5'h08;
  localparam logic [2:0] OP_FIELD_LO_PREFIX = 3'h3;
  localparam logic [7:0] FIELD_RESET = 8'h45;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COARSE_MASK = 16'hFFFC;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h5C;
  localparam logic [6:0] ADDR_PIN_LOW = 7'h23;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int FINE_TIME_MS = 120;
  localparam int COARSE_TIME_MS = 16;
  localparam int FINE_UNIT_CYCLES_DEF = FINE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS / int'(FIELD_RESET);
  localparam int COARSE_UNIT_CYCLES_DEF = COARSE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS / int'(FIELD_RESET);

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_AACK = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_WACK = 3'b100,
    BUS_READ = 3'b101,
    BUS_RACK = 3'b110
  } bus_state_t;

  typedef enum logic [1:0] {
    PWR_DOWN = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_CONT = 2'b10,
    PWR_ONCE = 2'b11
  } power_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_DOWN = 3'b001,
    CMD_WAKE = 3'b010,
    CMD_CLEAR = 3'b011,
    CMD_MEASURE = 3'b100,
    CMD_FIELD_HI = 3'b101,
    CMD_FIELD_LO = 3'b110
  } cmd_t;
endpackage

// ==== shared/meas_if.sv ====
// Interface between the command interpreter and the integrating converter.
`timescale 1ns/1ps
interface meas_if;
  logic start;
  logic abort;
  logic fine;
  logic [7:0] field;
  logic done;
  logic [15:0] value;
  modport ctrl (output start, output abort, output fine, output field, input done, input value);
  modport sensor (input start, input abort, input fine, input field, output done, output value);
endinterface

// ==== verilog/photo_integrator.sv ====
// Integrating converter timing: counts field units and accumulates the light rate.
`timescale 1ns/1ps
module photo_integrator
  import als_pkg::*;
#(
  parameter int FINE_UNIT_CYCLES = FINE_UNIT_CYCLES_DEF,
  parameter int COARSE_UNIT_CYCLES = COARSE_UNIT_CYCLES_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] light_rate,
  meas_if.sensor m
);
  localparam logic [31:0] FINE_LAST = 32'(FINE_UNIT_CYCLES - 1);
  localparam logic [31:0] COARSE_LAST = 32'(COARSE_UNIT_CYCLES - 1);
  localparam logic [7:0] ONE_UNIT = 8'h01;

  typedef struct packed {
    logic busy;
    logic fine;
    logic [7:0] units;
    logic [31:0] cyc;
    logic [23:0] acc;
    logic done;
    logic [15:0] value;
  } integ_state_t;

  integ_state_t s;
  integ_state_t next_s;

  // Saturates the sum to sixteen bits and drops the two low bits in coarse mode.
  function automatic logic [15:0] to_count(input logic [23:0] acc, input logic fine);
    logic [15:0] sat;
    sat = (|acc[23:16]) ? COUNT_MAX : acc[15:0];
    to_count = fine ? sat : (sat & COARSE_MASK);
  endfunction

  // One field unit lasts a fixed number of cycles, so the whole time grows with the field.
  always_comb
  begin
    logic [23:0] sum;
    sum = s.acc + {8'h00, light_rate};
    next_s = s;
    next_s.done = 1'b0;
    if (m.abort)
    begin
      next_s.busy = 1'b0;
    end
    else if (m.start)
    begin
      next_s.busy = 1'b1;
      next_s.fine = m.fine;
      next_s.units = (m.field == 8'h00) ? ONE_UNIT : m.field;
      next_s.cyc = '0;
      next_s.acc = '0;
    end
    else if (s.busy)
    begin
      if (s.cyc == (s.fine ? FINE_LAST : COARSE_LAST))
      begin
        next_s.cyc = '0;
        next_s.acc = sum;
        next_s.units = s.units - ONE_UNIT;
        if (s.units == ONE_UNIT)
        begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.value = to_count(sum, s.fine);
        end
      end
      else
      begin
        next_s.cyc = s.cyc + 32'h1;
      end
    end
  end

  // Registers the converter state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign m.done = s.done;
  assign m.value = s.value;
endmodule

// ==== verilog/ambient_light_top.sv ====
// Serial target, opcode interpreter and result readout of the ambient light sensor.
`timescale 1ns/1ps
module ambient_light_top
  import als_pkg::*;
#(
  parameter int FINE_UNIT_CYCLES = FINE_UNIT_CYCLES_DEF,
  parameter int COARSE_UNIT_CYCLES = COARSE_UNIT_CYCLES_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_pin,
  input wire logic [15:0] light_rate,
  output logic powered_down,
  output logic measuring,
  output logic [7:0] integration_time_field,
  output logic [15:0] result_count
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic addr_m;
    logic addr_s;
    bus_state_t bus;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic [7:0] tx_lo;
    logic rw;
    logic lo_next;
    logic got_byte;
    logic rack_ok;
    logic sda_release;
    logic [7:0] op;
    logic op_pend;
    power_state_t power;
    logic fine;
    logic [7:0] field;
    logic [15:0] result;
    logic start;
    logic abort;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  meas_if m ();

  // Sorts an opcode byte into one of the command classes.
  function automatic cmd_t decode_cmd(input logic [7:0] op);
    if (op == OP_POWER_DOWN)
    begin
      decode_cmd = CMD_DOWN;
    end
    else if (op == OP_POWER_ON)
    begin
      decode_cmd = CMD_WAKE;
    end
    else if (op == OP_CLEAR)
    begin
      decode_cmd = CMD_CLEAR;
    end
    else if (op == OP_CONT_FINE || op == OP_CONT_COARSE || op == OP_ONCE_FINE || op == OP_ONCE_COARSE)
    begin
      decode_cmd = CMD_MEASURE;
    end
    else if (op[7:FIELD_HI_W] == OP_FIELD_HI_PREFIX)
    begin
      decode_cmd = CMD_FIELD_HI;
    end
    else if (op[7:FIELD_LO_W] == OP_FIELD_LO_PREFIX)
    begin
      decode_cmd = CMD_FIELD_LO;
    end
    else
    begin
      decode_cmd = CMD_NONE;
    end
  endfunction

  // Serial bus engine, opcode execution and measurement sequencing.
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [6:0] my_addr;
    scl_rise = s.scl_s && !s.scl_d;
    scl_fall = !s.scl_s && s.scl_d;
    start_c = s.scl_s && s.scl_d && s.sda_d && !s.sda_s;
    stop_c = s.scl_s && s.scl_d && !s.sda_d && s.sda_s;
    my_addr = s.addr_s ? ADDR_PIN_HIGH : ADDR_PIN_LOW;
    next_s = s;
    next_s.start = 1'b0;
    next_s.abort = 1'b0;

    // Two-stage synchronisers for the pins; the second stage and, for SCL and SDA, its one-cycle delayed copy are read below.
    next_s.scl_m = scl_in;
    next_s.scl_s = s.scl_m;
    next_s.scl_d = s.scl_s;
    next_s.sda_m = sda_in;
    next_s.sda_s = s.sda_m;
    next_s.sda_d = s.sda_s;
    next_s.addr_m = addr_pin;
    next_s.addr_s = s.addr_m;

    // Bus framing: start and stop override any bit in progress.
    if (start_c)
    begin
      next_s.bus = BUS_ADDR;
      next_s.bits = '0;
      next_s.got_byte = 1'b0;
      next_s.sda_release = 1'b1;
    end
    else if (stop_c)
    begin
      next_s.bus = BUS_IDLE;
      next_s.sda_release = 1'b1;
    end
    else if (scl_rise)
    begin
      case (s.bus)
        BUS_ADDR, BUS_WRITE:
        begin
          next_s.shreg = {s.shreg[6:0], s.sda_s};
          next_s.bits = s.bits + 4'h1;
        end
        BUS_READ:
        begin
          next_s.bits = s.bits + 4'h1;
        end
        BUS_RACK:
        begin
          next_s.rack_ok = !s.sda_s;
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (s.bus)
        BUS_ADDR:
        begin
          if (s.bits == BITS_PER_BYTE)
          begin
            if (s.shreg[7:1] == my_addr)
            begin
              next_s.bus = BUS_AACK;
              next_s.rw = s.shreg[0];
              next_s.sda_release = 1'b0;
            end
            else
            begin
              next_s.bus = BUS_IDLE;
            end
          end
        end
        BUS_AACK:
        begin
          next_s.bits = '0;
          if (s.rw)
          begin
            // The whole result is caught here so both bytes belong to one conversion.
            next_s.bus = BUS_READ;
            next_s.shreg = s.result[15:8];
            next_s.tx_lo = s.result[7:0];
            next_s.lo_next = 1'b1;
            next_s.sda_release = s.result[15];
          end
          else
          begin
            next_s.bus = BUS_WRITE;
            next_s.sda_release = 1'b1;
          end
        end
        BUS_WRITE:
        begin
          if (s.bits == BITS_PER_BYTE)
          begin
            if (!s.got_byte)
            begin
              next_s.bus = BUS_WACK;
              next_s.op = s.shreg;
              next_s.op_pend = 1'b1;
              next_s.got_byte = 1'b1;
              next_s.sda_release = 1'b0;
            end
            else
            begin
              next_s.bus = BUS_IDLE;
            end
          end
        end
        BUS_WACK:
        begin
          next_s.bus = BUS_WRITE;
          next_s.bits = '0;
          next_s.sda_release = 1'b1;
        end
        BUS_READ:
        begin
          if (s.bits == BITS_PER_BYTE)
          begin
            next_s.bus = BUS_RACK;
            next_s.sda_release = 1'b1;
          end
          else
          begin
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.sda_release = s.shreg[6];
          end
        end
        BUS_RACK:
        begin
          if (s.rack_ok && s.lo_next)
          begin
            next_s.bus = BUS_READ;
            next_s.bits = '0;
            next_s.shreg = s.tx_lo;
            next_s.lo_next = 1'b0;
            next_s.sda_release = s.tx_lo[7];
          end
          else
          begin
            next_s.bus = BUS_IDLE;
          end
        end
        default:
        begin
        end
      endcase
    end

    // An opcode takes effect at the stop that closes its write.
    if (stop_c && s.op_pend)
    begin
      next_s.op_pend = 1'b0;
      case (decode_cmd(s.op))
        CMD_DOWN:
        begin
          next_s.power = PWR_DOWN;
          next_s.abort = 1'b1;
        end
        CMD_WAKE:
        begin
          next_s.power = PWR_IDLE;
          next_s.abort = 1'b1;
        end
        CMD_CLEAR:
        begin
          if (s.power != PWR_DOWN)
          begin
            next_s.result = RESULT_RESET;
          end
        end
        CMD_MEASURE:
        begin
          // A measurement opcode is accepted straight from power down.
          next_s.power = (s.op == OP_ONCE_FINE || s.op == OP_ONCE_COARSE) ? PWR_ONCE : PWR_CONT;
          next_s.fine = (s.op == OP_CONT_FINE || s.op == OP_ONCE_FINE);
          next_s.start = 1'b1;
        end
        CMD_FIELD_HI:
        begin
          next_s.field[7:FIELD_LO_W] = s.op[FIELD_HI_W-1:0];
        end
        CMD_FIELD_LO:
        begin
          next_s.field[FIELD_LO_W-1:0] = s.op[FIELD_LO_W-1:0];
        end
        default:
        begin
          // Unknown opcodes were acknowledged and change nothing.
        end
      endcase
    end

    // A finished conversion is stored last and wins over a clear; one meeting a fresh start or abort is dropped.
    if (m.done && !s.abort && !s.start && !next_s.abort && !next_s.start)
    begin
      if (s.power == PWR_CONT)
      begin
        next_s.result = m.value;
        next_s.start = 1'b1;
      end
      else if (s.power == PWR_ONCE)
      begin
        next_s.result = m.value;
        next_s.power = PWR_DOWN;
      end
    end
  end

  // Registers all state; the reset pin holds it at reset values and powered down.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
      s.sda_release <= 1'b1;
      s.field <= FIELD_RESET;
      s.result <= RESULT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Measurement controls toward the converter.
  assign m.start = s.start;
  assign m.abort = s.abort;
  assign m.fine = s.fine;
  assign m.field = s.field;

  photo_integrator #(
    .FINE_UNIT_CYCLES(FINE_UNIT_CYCLES),
    .COARSE_UNIT_CYCLES(COARSE_UNIT_CYCLES)
  ) u_integrator (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .light_rate(light_rate),
    .m(m)
  );

  // Open-drain data pin: the enable is low while the line is pulled low.
  assign sda_out = 1'b0;
  assign sda_oe_n = s.sda_release;
  assign powered_down = (s.power == PWR_DOWN);
  assign measuring = (s.power == PWR_CONT) || (s.power == PWR_ONCE);
  assign integration_time_field = s.field;
  assign result_count = s.result;
endmodule

// ==== dv/ambient_light_properties.sv ====
// Concurrent checks on the pins and status outputs of the ambient light sensor.
`timescale 1ns/1ps
module ambient_light_checker
  import als_pkg::*;
#(
  parameter int FINE_UNIT_CYCLES = FINE_UNIT_CYCLES_DEF,
  parameter int COARSE_UNIT_CYCLES = COARSE_UNIT_CYCLES_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic addr_pin,
  input wire logic [15:0] light_rate,
  input wire logic powered_down,
  input wire logic measuring,
  input wire logic [7:0] integration_time_field,
  input wire logic [15:0] result_count
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // All checks run on the system clock and pause while reset is low.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Status and registers leave reset at their initial values with SDA released.
  property p_reset_state;
    $rose(rst_n) |-> powered_down && !measuring && sda_oe_n
      && integration_time_field == FIELD_RESET && result_count == RESULT_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state after reset release wrong");
  // A measurement ends only by completing into power down or by an opcode taken at a stop.
  property p_measure_end;
    $fell(measuring) |-> powered_down || ($past(scl_in) && $past(sda_in));
  endproperty
  a_measure_end: assert property (p_measure_end) else $error("measurement ended wrongly");
  // A measurement begins only when a stop has ended the write, and stays on for the next three cycles.
  property p_start_at_stop;
    $rose(measuring) |-> $past(scl_in) && $past(sda_in) ##1 measuring[*3];
  endproperty
  a_start_at_stop: assert property (p_start_at_stop) else $error("measurement start wrong");
  property p_down_keeps_result;
    powered_down && $past(powered_down) |-> $stable(result_count);
  endproperty
  a_down_keeps_result: assert property (p_down_keeps_result) else $error("result moved while down");
  property p_result_from_conv;
    $changed(result_count) && result_count != RESULT_RESET |-> $past(measuring);
  endproperty
  a_result_from_conv: assert property (p_result_from_conv) else $error("result set without conversion");
  // A result change never happens in power down and never disturbs the field.
  property p_clear_scope;
    $changed(result_count) |-> !$past(powered_down) && $stable(integration_time_field);
  endproperty
  a_clear_scope: assert property (p_clear_scope) else $error("result change out of scope");
  property p_field_at_stop;
    $changed(integration_time_field) |-> $past(scl_in) && $past(sda_in);
  endproperty
  a_field_at_stop: assert property (p_field_at_stop) else $error("field changed outside stop");
  // One field opcode updates either the upper three or the lower five bits.
  property p_field_one_half;
    $changed(integration_time_field) |-> ((integration_time_field ^ $past(integration_time_field)) & 8'hE0) == 8'h00
      || ((integration_time_field ^ $past(integration_time_field)) & 8'h1F) == 8'h00;
  endproperty
  a_field_one_half: assert property (p_field_one_half) else $error("both field halves changed");
  c_single_done: cover property ($rose(powered_down) && $past(measuring));
  c_ack_driven: cover property ($fell(sda_oe_n));
  c_field_write: cover property ($changed(integration_time_field));
endmodule

bind ambient_light_top ambient_light_checker #(
  .FINE_UNIT_CYCLES(FINE_UNIT_CYCLES),
  .COARSE_UNIT_CYCLES(COARSE_UNIT_CYCLES)
) u_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_pin(addr_pin), .light_rate(light_rate), .powered_down(powered_down), .measuring(measuring),
  .integration_time_field(integration_time_field), .result_count(result_count)
);

// ==== dv/host_bus_model.sv ====
// Bus controller model that drives SCL and SDA of the sensor and reads the line back.
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  // ----------------------------------------
  // Bus conditions and transfers
  // ----------------------------------------
  // Both lines idle released, so the pull-up holds them high.
  initial scl = 1'h1;
  initial sda_m = 1'h1;

  // Waits n falling clock edges; the lines only move there.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Sends a start when go is set, else a stop; SDA moves while SCL is high.
  task automatic cond(input logic go);
    sda_m = go;
    tick(2);
    scl = 1'h1;
    tick(4);
    sda_m = ~go;
    tick(4);
    if (go)
      scl = 1'h0;
    tick(2);
  endtask

  // Shifts a byte MSB first and one acknowledge slot, sampling SDA mid high phase.
  task automatic slot(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    logic [8:0] seen;
    for (int i = 8; i >= 0; i--)
    begin
      sda_m = i > 0 ? tx[i - 1] : ack_tx;
      tick(2);
      scl = 1'h1;
      tick(2);
      seen[i] = sda_line;
      tick(2);
      scl = 1'h0;
      tick(2);
    end
    rx = seen[8:1];
    ack_rx = seen[0];
  endtask

  // Writes one opcode and ends with a stop; acked is set when both bytes were acknowledged.
  task automatic write_op(input logic [6:0] addr, input logic [7:0] op, output logic acked);
    logic [7:0] rx;
    logic a0;
    logic a1;
    a1 = 1'h1;
    cond(1'h1);
    slot({addr, 1'h0}, 1'h1, rx, a0);
    if (a0 == 1'h0)
      slot(op, 1'h1, rx, a1);
    cond(1'h0);
    acked = ~a0 & ~a1;
  endtask

  // Reads the two result bytes, acknowledging the first and not the second.
  task automatic read_res(input logic [6:0] addr, output logic [15:0] value);
    logic [7:0] rx;
    logic a0;
    cond(1'h1);
    slot({addr, 1'h1}, 1'h1, rx, a0);
    slot(8'hFF, 1'h0, value[15:8], a0);
    slot(8'hFF, 1'h1, value[7:0], a0);
    cond(1'h0);
  endtask
endmodule

// ==== dv/tb_ambient_light_i2c_command_readout.sv ====
// Self-checking bench for the ambient light command interpreter and result readout.
`timescale 1ns/1ps
module tb_ambient_light_i2c_command_readout
  import als_pkg::*;
;
  localparam logic [7:0] FIELD_SMALL = 8'h03;
  logic clk_sys = 1'h0;
  logic rst_n;
  logic addr_pin;
  logic [15:0] light_rate;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe_n;
  logic powered_down;
  logic measuring;
  logic [7:0] integration_time_field;
  logic [15:0] result_count;
  logic sda_line;
  logic acked;
  logic [15:0] word;
  int fail_count = 0;
  int n_tests = 0;

  // ----------------------------------------
  // Clock, wiring and checks
  // ----------------------------------------
  // Open-drain line: the pull-up wins unless either side pulls low.
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  always #12.5 clk_sys = ~clk_sys;

  ambient_light_top #(.FINE_UNIT_CYCLES(20), .COARSE_UNIT_CYCLES(5)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_pin(addr_pin), .light_rate(light_rate), .powered_down(powered_down), .measuring(measuring),
    .integration_time_field(integration_time_field), .result_count(result_count));
  host_bus_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic state_is(input logic pd, input logic m, input logic [7:0] f, input logic [15:0] r);
    check(powered_down, pd);
    check(measuring, m);
    check(integration_time_field, f);
    check(result_count, r);
  endtask

  // Writes one opcode to the high address and expects it acknowledged.
  task automatic send(input logic [7:0] code);
    host.write_op(ADDR_PIN_HIGH, code, acked);
    check(acked, 1'h1);
    repeat (2) @(negedge clk_sys);
  endtask

  // Waits a bounded time for a conversion to store the expected count.
  task automatic wait_for(input logic [15:0] exp);
    for (int i = 0; i < 3000 && result_count !== exp; i++)
      @(negedge clk_sys);
    check(result_count, exp);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence of tests.
  initial
  begin
    rst_n = 1'h0;
    addr_pin = 1'h0;
    light_rate = 16'h0102;
    repeat (40) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    state_is(1'h1, 1'h0, FIELD_RESET, RESULT_RESET);
    $display("test reset values done");
    for (int p = 0; p < 2; p++)
    begin
      addr_pin = p[0];
      repeat (4) @(negedge clk_sys);
      host.write_op(p[0] ? ADDR_PIN_HIGH : ADDR_PIN_LOW, OP_POWER_ON, acked);
      check(acked, 1'h1);
      host.write_op(p[0] ? ADDR_PIN_LOW : ADDR_PIN_HIGH, OP_POWER_DOWN, acked);
      check(acked, 1'h0);
      state_is(1'h0, 1'h0, FIELD_RESET, RESULT_RESET);
    end
    $display("test address select done");
    send({OP_FIELD_HI_PREFIX, FIELD_SMALL[7:5]});
    send({OP_FIELD_LO_PREFIX, FIELD_SMALL[4:0]});
    check(integration_time_field, FIELD_SMALL);
    send(OP_ONCE_FINE);
    check(measuring, 1'h1);
    wait_for(light_rate * 16'(FIELD_SMALL));
    repeat (3) @(negedge clk_sys);
    check(powered_down, 1'h1);
    host.read_res(ADDR_PIN_HIGH, word);
    check(word, light_rate * 16'(FIELD_SMALL));
    send(OP_CLEAR);
    check(result_count, light_rate * 16'(FIELD_SMALL));
    send(OP_POWER_ON);
    send(OP_CLEAR);
    state_is(1'h0, 1'h0, FIELD_SMALL, RESULT_RESET);
    send(OP_POWER_DOWN);
    send(OP_ONCE_COARSE);
    wait_for(light_rate * 16'(FIELD_SMALL) & COARSE_MASK);
    $display("test single measurements done");
    send(OP_CONT_FINE);
    wait_for(light_rate * 16'(FIELD_SMALL));
    light_rate = 16'h0011;
    wait_for(light_rate * 16'(FIELD_SMALL));
    send(OP_CONT_COARSE);
    wait_for(light_rate * 16'(FIELD_SMALL) & COARSE_MASK);
    send(8'hFF);
    state_is(1'h0, 1'h1, FIELD_SMALL, light_rate * 16'(FIELD_SMALL) & COARSE_MASK);
    send(OP_POWER_DOWN);
    check(measuring, 1'h0);
    check(powered_down, 1'h1);
    $display("test continuous measurements done");
    send(OP_CONT_FINE);
    wait_for(light_rate * 16'(FIELD_SMALL));
    rst_n = 1'h0;
    repeat (40) @(negedge clk_sys);
    state_is(1'h1, 1'h0, FIELD_RESET, RESULT_RESET);
    rst_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    state_is(1'h1, 1'h0, FIELD_RESET, RESULT_RESET);
    // A second opcode byte in one write is refused; only the first one acts at the stop.
    host.cond(1'h1);
    host.slot({ADDR_PIN_HIGH, 1'h0}, 1'h1, word[7:0], acked);
    check(acked, 1'h0);
    host.slot({OP_FIELD_HI_PREFIX, 3'h4}, 1'h1, word[7:0], acked);
    check(acked, 1'h0);
    host.slot(OP_POWER_ON, 1'h1, word[7:0], acked);
    check(acked, 1'h1);
    host.cond(1'h0);
    repeat (2) @(negedge clk_sys);
    state_is(1'h1, 1'h0, {3'h4, FIELD_RESET[4:0]}, RESULT_RESET);
    $display("test mid-run reset done");
    close_out();
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
endmodule
